// >>> core/sod_output_port.sv
// Sixteen-channel digital output port with overload diagnostics.
// Assumes the backplane interface delivers image writes, record reads and
// status flags as same-clock logic; overload and fault flags come from pins.
`timescale 1ns/1ps
module sod_output_port #(
    parameter int CHANNELS = sod_pkg::CHANNELS,
    parameter int BLINK_HALF_US = sod_pkg::BLINK_HALF_US
) (
    input wire logic sys_clk,
    input wire logic reset,
    // Output image write from the backplane
    input wire logic image_wr,
    input wire logic [0:0] image_addr,
    input wire logic [1:0] image_byte_en,
    input wire logic [15:0] image_wdata,
    // Diagnostic record read
    input wire logic rec_rd,
    input wire logic [7:0] rec_num,
    input wire logic [4:0] rec_index,
    output logic [7:0] rec_rdata,
    output logic rec_valid,
    output logic rec_error,
    // Configuration and status flags
    input wire logic diag_irq_enable,
    input wire logic bus_fail,
    input wire logic config_error,
    // Fault pins from the output stage
    input wire logic overload_pin,
    input wire logic module_fail_pin,
    input wire logic internal_err_pin,
    input wire logic external_err_pin,
    // Field side
    output logic [15:0] out_lines,
    output logic [15:0] chan_leds,
    output logic status_green,
    output logic status_red,
    output logic diag_incoming,
    output logic diag_going,
    output logic [7:0] input_image_bytes
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Image, record and pin mapping are fixed at sixteen lines
    if (CHANNELS != 16) begin : g_bad_channels
        $error("Only sixteen channels are supported");
    end
    // A zero half period would stop the blink divider for good
    if (BLINK_HALF_US < 1) begin : g_bad_blink
        $error("Blink half period must be at least one microsecond");
    end
    // The microsecond base needs at least one clock per microsecond
    if (sod_pkg::TICKS_PER_US < 1) begin : g_bad_tick
        $error("Clock too slow for a microsecond tick");
    end
    // Timestamp must close the record
    if (sod_pkg::IDX_TIMESTAMP + 5'h04 != 5'(sod_pkg::DIAG_RECORD_BYTES)) begin : g_bad_layout
        $error("Record layout and length disagree");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] ovl_sync;
        logic [2:0] mf_sync;
        logic [2:0] ie_sync;
        logic [2:0] ee_sync;
        logic ovl;
        logic mf;
        logic ie;
        logic ee;
        logic diag_active;
        logic [15:0] image;
        logic [31:0] us_count;
        logic [31:0] stamp;
        logic blink;
        sod_pkg::sod_status_leds_t leds;
        sod_pkg::sod_diag_event_t ev;
        logic [7:0] rdata;
        logic rvalid;
        logic rerr;
        logic [7:0] in_image;
    } sod_state_t;

    sod_state_t st_q, st_d;

    logic us_tick;
    logic blink_tick;
    logic [7:0] summary;
    logic [7:0] rec_byte;
    logic fault_now;

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    sod_tick_div #(
        .DIV(sod_pkg::TICKS_PER_US)
    ) u_us_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .en_in(1'b1),
        .tick(us_tick)
    );

    // Blink half period counted in microseconds, one shared phase for red and green
    sod_tick_div #(
        .DIV(BLINK_HALF_US)
    ) u_blink_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .en_in(us_tick),
        .tick(blink_tick)
    );

    // ----------------------------------------
    // Record contents
    // ----------------------------------------
    always_comb begin
        summary = sod_pkg::RESERVED_BYTE;
        summary[sod_pkg::SUM_MODULE_FAIL] = st_q.mf;
        summary[sod_pkg::SUM_INTERNAL] = st_q.ie;
        summary[sod_pkg::SUM_EXTERNAL] = st_q.ee;
        summary[sod_pkg::SUM_OVERLOAD] = st_q.ovl;
        summary[sod_pkg::SUM_PARAM] = config_error;
    end

    always_comb begin
        // Reserved bytes and anything past the record read as zero
        rec_byte = sod_pkg::RESERVED_BYTE;
        case (rec_index)
            sod_pkg::IDX_SUMMARY: begin
                rec_byte = summary;
            end
            sod_pkg::IDX_MODULE_CLASS: begin
                rec_byte = sod_pkg::MODULE_CLASS_BYTE;
            end
            sod_pkg::IDX_RESERVED_C: begin
                rec_byte = sod_pkg::RESERVED_BYTE;
            end
            sod_pkg::IDX_RESERVED_D: begin
                rec_byte = sod_pkg::RESERVED_BYTE;
            end
            sod_pkg::IDX_CHANNEL_KIND: begin
                rec_byte = sod_pkg::CHANNEL_KIND_BYTE;
            end
            sod_pkg::IDX_BITS_PER_CH: begin
                rec_byte = sod_pkg::DIAG_BITS_PER_CHANNEL;
            end
            sod_pkg::IDX_CHANNEL_COUNT: begin
                rec_byte = sod_pkg::CHANNEL_COUNT_BYTE;
            end
            sod_pkg::IDX_FAULT_SUMMARY: begin
                rec_byte = sod_pkg::RESERVED_BYTE;
            end
            // No per-channel diagnosis here: all eight channel bytes stay zero
            sod_pkg::IDX_PER_CHANNEL,
            sod_pkg::IDX_PER_CHANNEL + 5'h01,
            sod_pkg::IDX_PER_CHANNEL + 5'h02,
            sod_pkg::IDX_PER_CHANNEL + 5'h03,
            sod_pkg::IDX_PER_CHANNEL + 5'h04,
            sod_pkg::IDX_PER_CHANNEL + 5'h05,
            sod_pkg::IDX_PER_CHANNEL + 5'h06,
            sod_pkg::IDX_PER_CHANNEL + 5'h07: begin
                rec_byte = sod_pkg::RESERVED_BYTE;
            end
            sod_pkg::IDX_TIMESTAMP: begin
                rec_byte = st_q.stamp[7:0];
            end
            sod_pkg::IDX_TIMESTAMP + 5'h01: begin
                rec_byte = st_q.stamp[15:8];
            end
            sod_pkg::IDX_TIMESTAMP + 5'h02: begin
                rec_byte = st_q.stamp[23:16];
            end
            sod_pkg::IDX_TIMESTAMP + 5'h03: begin
                rec_byte = st_q.stamp[31:24];
            end
            default: begin
                rec_byte = sod_pkg::RESERVED_BYTE;
            end
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.ev = '0;
        st_d.rvalid = 1'b0;
        st_d.rerr = 1'b0;

        // ----------------------------------------
        // Fault pins
        // ----------------------------------------
        // Three-stage synchronisers; a change counts once stages two and three agree
        // The agreement test also drops a pin glitch shorter than one clock
        st_d.ovl_sync = {st_q.ovl_sync[1:0], overload_pin};
        st_d.mf_sync = {st_q.mf_sync[1:0], module_fail_pin};
        st_d.ie_sync = {st_q.ie_sync[1:0], internal_err_pin};
        st_d.ee_sync = {st_q.ee_sync[1:0], external_err_pin};
        if (st_q.ovl_sync[2] == st_q.ovl_sync[1]) begin
            st_d.ovl = st_q.ovl_sync[2];
        end
        if (st_q.mf_sync[2] == st_q.mf_sync[1]) begin
            st_d.mf = st_q.mf_sync[2];
        end
        if (st_q.ie_sync[2] == st_q.ie_sync[1]) begin
            st_d.ie = st_q.ie_sync[2];
        end
        if (st_q.ee_sync[2] == st_q.ee_sync[1]) begin
            st_d.ee = st_q.ee_sync[2];
        end

        // ----------------------------------------
        // Microsecond counter
        // ----------------------------------------
        // Free-running microsecond counter, wraps naturally at 32 bits
        if (us_tick) begin
            st_d.us_count = st_q.us_count + 32'h0000_0001;
        end

        // ----------------------------------------
        // Output image
        // ----------------------------------------
        // Output image write, byte lanes independent
        // A disabled lane keeps its value, so one byte can change alone
        if (image_wr && image_addr == sod_pkg::OUT_IMAGE_OFFSET) begin
            if (image_byte_en[0]) begin
                st_d.image[7:0] = image_wdata[7:0];
            end
            if (image_byte_en[1]) begin
                st_d.image[15:8] = image_wdata[15:8];
            end
        end

        // ----------------------------------------
        // Diagnostic events
        // ----------------------------------------
        // Diagnostic events; only overload is an interrupt source
        if (diag_irq_enable && st_q.ovl && !st_q.diag_active) begin
            st_d.diag_active = 1'b1;
            st_d.ev.incoming = 1'b1;
            st_d.stamp = st_q.us_count;
        end else if (st_q.diag_active && !st_q.ovl) begin
            // Going is raised even if the enable dropped meanwhile
            st_d.diag_active = 1'b0;
            st_d.ev.going = 1'b1;
        end

        // ----------------------------------------
        // Status bar
        // ----------------------------------------
        if (blink_tick) begin
            st_d.blink = ~st_q.blink;
        end
        // Any filtered fault outranks the configuration blink
        fault_now = st_q.ovl || st_q.mf || st_q.ie || st_q.ee;
        if (fault_now) begin
            st_d.leds.red = 1'b1;
        end else if (config_error) begin
            st_d.leds.red = st_q.blink;
        end else begin
            st_d.leds.red = 1'b0;
        end
        if (bus_fail) begin
            st_d.leds.green = st_q.blink;
        end else begin
            st_d.leds.green = !(fault_now || config_error);
        end

        // ----------------------------------------
        // Record read
        // ----------------------------------------
        // Record read: one-cycle answer, wrong record number flagged
        // Index decoded live: the byte shows the state at the request edge
        if (rec_rd) begin
            if (rec_num == sod_pkg::DIAG_RECORD_NUM) begin
                st_d.rvalid = 1'b1;
                st_d.rdata = rec_byte;
            end else begin
                st_d.rerr = 1'b1;
                st_d.rdata = sod_pkg::RESERVED_BYTE;
            end
        end

        // ----------------------------------------
        // Input image
        // ----------------------------------------
        // Nothing is ever offered to the controller's input image
        st_d.in_image = 8'h00;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= '0;
            // No line may switch before the controller's first write
            st_q.image <= sod_pkg::OUT_IMAGE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------
    assign out_lines = st_q.image;
    assign chan_leds = st_q.image;
    assign status_green = st_q.leds.green;
    assign status_red = st_q.leds.red;
    assign diag_incoming = st_q.ev.incoming;
    assign diag_going = st_q.ev.going;
    assign rec_rdata = st_q.rdata;
    assign rec_valid = st_q.rvalid;
    assign rec_error = st_q.rerr;
    // Constant zero: the module contributes nothing to the input image
    assign input_image_bytes = st_q.in_image;

endmodule : sod_output_port

// >>> core/sod_tick_div.sv
// Enable-pulse divider: one-cycle pulse every DIV cycles of the input enable.
// Assumes the same clock and synchronous reset as its parent.
`timescale 1ns/1ps
module sod_tick_div #(
    parameter int DIV = 10
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic en_in,
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } sod_div_state_t;

    sod_div_state_t st_q, st_d;

    if (DIV < 1) begin : g_bad_div
        $error("DIV must be at least 1");
    end

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (en_in) begin
            if (st_q.cnt == 32'(DIV - 1)) begin
                st_d.cnt = 32'h0000_0000;
                st_d.tick = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule : sod_tick_div

// >>> shared/sod_pkg.sv
// Shared constants and carrier types for the sixteen-channel output port.
// Assumes a single 10 MHz system clock.
package sod_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int TICKS_PER_US = CLK_HZ / US_PER_S;
    localparam int BLINK_HZ = 1;
    // Half period of the 1 Hz blink, in microseconds
    localparam int BLINK_HALF_US = US_PER_S / (2 * BLINK_HZ);

    // ----------------------------------------
    // Output image and record addressing
    // ----------------------------------------
    localparam logic [0:0] OUT_IMAGE_OFFSET = 1'h0;
    localparam int CHANNELS = 16;
    localparam logic [7:0] DIAG_RECORD_NUM = 8'h01;
    localparam int DIAG_RECORD_BYTES = 20;
    localparam logic [4:0] IDX_SUMMARY = 5'h00;
    localparam logic [4:0] IDX_MODULE_CLASS = 5'h01;
    localparam logic [4:0] IDX_RESERVED_C = 5'h02;
    localparam logic [4:0] IDX_RESERVED_D = 5'h03;
    localparam logic [4:0] IDX_CHANNEL_KIND = 5'h04;
    localparam logic [4:0] IDX_BITS_PER_CH = 5'h05;
    localparam logic [4:0] IDX_CHANNEL_COUNT = 5'h06;
    localparam logic [4:0] IDX_FAULT_SUMMARY = 5'h07;
    localparam logic [4:0] IDX_PER_CHANNEL = 5'h08;
    localparam logic [4:0] IDX_TIMESTAMP = 5'h10;

    // ----------------------------------------
    // Record contents and reset values
    // ----------------------------------------
    localparam logic [7:0] MODULE_CLASS_BYTE = 8'h0F;
    localparam logic [7:0] CHANNEL_KIND_BYTE = 8'h72;
    localparam logic [7:0] DIAG_BITS_PER_CHANNEL = 8'h00;
    localparam logic [7:0] CHANNEL_COUNT_BYTE = 8'h00;
    localparam logic [7:0] RESERVED_BYTE = 8'h00;
    localparam logic [15:0] OUT_IMAGE_RESET = 16'h0000;
    localparam int SUM_MODULE_FAIL = 0;
    localparam int SUM_INTERNAL = 1;
    localparam int SUM_EXTERNAL = 2;
    localparam int SUM_OVERLOAD = 4;
    localparam int SUM_PARAM = 7;

    typedef struct packed {
        logic green;
        logic red;
    } sod_status_leds_t;

    typedef struct packed {
        logic incoming;
        logic going;
    } sod_diag_event_t;

endpackage : sod_pkg

// >>> tb/sixteen_channel_output_diag_test.sv
// Top-level bench for the sixteen-channel output port.
// Assumes the checker and controller model are compiled first.
`timescale 1ns/1ps
module sixteen_channel_output_diag_test;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic diag_irq_enable = 1'h0;
    logic bus_fail = 1'h0;
    logic config_error = 1'h0;
    logic overload_pin = 1'h0;
    logic module_fail_pin = 1'h0;
    logic internal_err_pin = 1'h0;
    logic external_err_pin = 1'h0;
    logic image_wr, rec_rd, rec_valid, rec_error, status_green, status_red, diag_incoming, diag_going;
    logic [0:0] image_addr;
    logic [1:0] image_byte_en, st;
    logic [15:0] image_wdata, out_lines, chan_leds;
    logic [7:0] rec_num, rec_rdata, input_image_bytes, d;
    logic [4:0] rec_index;
    logic [31:0] stamp, t_inc;
    logic [31:0] cyc = 32'h0;
    logic [31:0] inc_cnt = 32'h0;
    logic [31:0] go_cnt = 32'h0;
    logic [7:0] bad [3] = '{8'h00, 8'h02, 8'hFF};
    int error_cnt = 0;
    int comparisons = 0;
    // Short blink half period so both blink rates can be timed within the run
    localparam int BLINK_US = 20;
    int blink_n;
    logic [7:0] exp_b;

    sod_output_port #(.BLINK_HALF_US(BLINK_US)) i_sod_output_port (.*);
    sod_cpu_model i_sod_cpu_model (.*);

    always #50 sys_clk = ~sys_clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // Cycles between two toggles of a status led; sel 0 is green, 1 is red
    task automatic blink_period(input logic sel, output int n);
        logic prev;
        prev = sel ? status_red : status_green;
        n = 0;
        while ((sel ? status_red : status_green) === prev && n < 2 * BLINK_US * sod_pkg::TICKS_PER_US) begin
            @(negedge sys_clk);
            n++;
        end
        prev = sel ? status_red : status_green;
        n = 0;
        while ((sel ? status_red : status_green) === prev && n < 2 * BLINK_US * sod_pkg::TICKS_PER_US) begin
            @(negedge sys_clk);
            n++;
        end
    endtask : blink_period

    // Event counters and a hang limit well above the run length
    always @(posedge sys_clk) begin
        cyc <= reset ? 32'h0 : cyc + 32'h1;
        if (diag_incoming === 1'h1) begin
            inc_cnt <= inc_cnt + 32'h1;
            t_inc <= cyc;
        end
        if (diag_going === 1'h1) go_cnt <= go_cnt + 32'h1;
        if (cyc >= 32'h1388) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        repeat (3) @(negedge sys_clk);
        reset = 1'h0;
        repeat (2) @(negedge sys_clk);
        check("lines after reset", out_lines, 32'h0);
        check("green healthy", status_green, 32'h1);
        check("input bytes", input_image_bytes, 32'h0);
        i_sod_cpu_model.wr(1'h0, 2'h3, 16'hA5C3);
        check("lines", out_lines, 32'hA5C3);
        check("leds", chan_leds, 32'hA5C3);
        i_sod_cpu_model.wr(1'h0, 2'h2, 16'h5A3C);
        check("high byte only", out_lines, 32'h5AC3);
        i_sod_cpu_model.wr(1'h1, 2'h3, 16'hFFFF);
        check("refused address", out_lines, 32'h5AC3);
        i_sod_cpu_model.wr(1'h0, 2'h1, 16'h0000);
        check("low byte cleared", chan_leds, 32'h5A00);
        for (int i = 0; i < 32; i++) begin
            if (i < 16 || i > 19) begin
                i_sod_cpu_model.rd(8'h01, i[4:0], d, st);
                exp_b = sod_pkg::RESERVED_BYTE;
                if (i == 1) exp_b = sod_pkg::MODULE_CLASS_BYTE;
                if (i == 4) exp_b = sod_pkg::CHANNEL_KIND_BYTE;
                check("record byte", {st, d}, {2'h1, exp_b});
            end
        end
        foreach (bad[k]) begin
            i_sod_cpu_model.rd(bad[k], 5'h01, d, st);
            check("wrong record", {st, d}, {2'h2, 8'h00});
        end
        module_fail_pin = 1'h1;
        internal_err_pin = 1'h1;
        external_err_pin = 1'h1;
        config_error = 1'h1;
        repeat (8) @(negedge sys_clk);
        i_sod_cpu_model.rd(8'h01, 5'h00, d, st);
        check("summary faults", d, 32'h87);
        check("red on fault", status_red, 32'h1);
        check("green on fault", status_green, 32'h0);
        {module_fail_pin, internal_err_pin, external_err_pin, config_error} = 4'h0;
        overload_pin = 1'h1;
        repeat (10) @(negedge sys_clk);
        check("red on overload", status_red, 32'h1);
        check("no event disabled", inc_cnt, 32'h0);
        i_sod_cpu_model.rd(8'h01, 5'h00, d, st);
        check("summary overload", d, 32'h10);
        overload_pin = 1'h0;
        repeat (10) @(negedge sys_clk);
        check("red cleared", status_red, 32'h0);
        diag_irq_enable = 1'h1;
        overload_pin = 1'h1;
        repeat (10) @(negedge sys_clk);
        check("incoming", inc_cnt, 32'h1);
        for (int b = 0; b < 4; b++) begin
            i_sod_cpu_model.rd(8'h01, 5'h10 + b[4:0], d, st);
            stamp[8*b +: 8] = d;
        end
        check("stamp", (stamp + 32'h1 >= t_inc / 32'hA) && (stamp <= t_inc / 32'hA + 32'h1), 32'h1);
        overload_pin = 1'h0;
        repeat (10) @(negedge sys_clk);
        check("going", go_cnt, 32'h1);
        bus_fail = 1'h1;
        repeat (2) @(negedge sys_clk);
        blink_period(1'h0, blink_n);
        check("green blink", blink_n, BLINK_US * sod_pkg::TICKS_PER_US);
        bus_fail = 1'h0;
        config_error = 1'h1;
        repeat (2) @(negedge sys_clk);
        check("green config", status_green, 32'h0);
        blink_period(1'h1, blink_n);
        check("red blink", blink_n, BLINK_US * sod_pkg::TICKS_PER_US);
        config_error = 1'h0;
        reset = 1'h1;
        repeat (3) @(negedge sys_clk);
        reset = 1'h0;
        repeat (2) @(negedge sys_clk);
        check("lines after second reset", out_lines, 32'h0);
        check("leds after second reset", chan_leds, 32'h0);
        check("green after second reset", status_green, 32'h1);
        i_sod_cpu_model.wr(1'h0, 2'h1, 16'h0081);
        check("lines after rewrite", out_lines, 32'h0081);
        report_and_stop();
    end
endmodule : sixteen_channel_output_diag_test

bind sod_output_port sod_output_port_checker #(.CHANNELS(CHANNELS)) i_sod_output_port_checker (.*);

// >>> tb/sod_cpu_model.sv
// Controller model: writes the output image and reads record bytes.
// Assumes the bench calls its tasks; lines change on the falling edge.
`timescale 1ns/1ps
module sod_cpu_model (
    input wire logic sys_clk,
    output logic image_wr,
    output logic [0:0] image_addr,
    output logic [1:0] image_byte_en,
    output logic [15:0] image_wdata,
    output logic rec_rd,
    output logic [7:0] rec_num,
    output logic [4:0] rec_index,
    input wire logic [7:0] rec_rdata,
    input wire logic rec_valid,
    input wire logic rec_error
);
    initial begin
        image_wr = 1'h0;
        image_addr = 1'h0;
        image_byte_en = 2'h0;
        image_wdata = 16'h0000;
        rec_rd = 1'h0;
        rec_num = 8'h00;
        rec_index = 5'h00;
    end

    task automatic wr(input logic [0:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge sys_clk);
        image_wr = 1'h1;
        image_addr = a;
        image_byte_en = be;
        image_wdata = d;
        @(negedge sys_clk);
        image_wr = 1'h0;
        // Released data scrambled so a stale value never passes
        image_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] n, input logic [4:0] i, output logic [7:0] d, output logic [1:0] st);
        @(negedge sys_clk);
        rec_rd = 1'h1;
        rec_num = n;
        rec_index = i;
        @(negedge sys_clk);
        rec_rd = 1'h0;
        rec_index = ~i;
        d = rec_rdata;
        st = {rec_error, rec_valid};
    endtask : rd
endmodule : sod_cpu_model

// >>> tb/sod_output_port_checker.sv
// Concurrent checks on the output port's pins.
// Assumes it is bound to the port module and shares its clock and reset.
`timescale 1ns/1ps
module sod_output_port_checker #(
    parameter int CHANNELS = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic image_wr,
    input wire logic [0:0] image_addr,
    input wire logic [1:0] image_byte_en,
    input wire logic [15:0] image_wdata,
    input wire logic rec_rd,
    input wire logic [7:0] rec_num,
    input wire logic [4:0] rec_index,
    input wire logic [7:0] rec_rdata,
    input wire logic rec_valid,
    input wire logic rec_error,
    input wire logic diag_irq_enable,
    input wire logic overload_pin,
    input wire logic [15:0] out_lines,
    input wire logic [15:0] chan_leds,
    input wire logic status_red,
    input wire logic diag_incoming,
    input wire logic [7:0] input_image_bytes
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    leds_follow_a: assert property (chan_leds[CHANNELS-1:0] == out_lines[CHANNELS-1:0])
        else $error("channel leds differ from lines");
    no_input_a: assert property (input_image_bytes == 8'h00)
        else $error("input image bytes not zero");
    low_byte_a: assert property (image_wr && image_addr == 1'h0 && image_byte_en[0]
        |=> out_lines[7:0] == $past(image_wdata[7:0])) else $error("low byte not written");
    high_byte_a: assert property (image_wr && image_addr == 1'h0 && image_byte_en[1]
        |=> out_lines[15:8] == $past(image_wdata[15:8])) else $error("high byte not written");
    image_hold_a: assert property (!(image_wr && image_addr == 1'h0) |=> $stable(out_lines))
        else $error("lines changed without a write");
    read_answer_a: assert property (rec_rd |=> rec_valid ^ rec_error)
        else $error("read not answered in one cycle");
    wrong_record_a: assert property (rec_rd && rec_num != 8'h01 |=> rec_error && rec_rdata == 8'h00)
        else $error("wrong record accepted");
    class_byte_a: assert property (rec_rd && rec_num == 8'h01 && rec_index == 5'h01
        |=> rec_rdata == 8'h0F) else $error("module class byte wrong");
    red_overload_a: assert property (overload_pin [*8] |-> status_red)
        else $error("red dark during overload");
    incoming_enabled_a: assert property (diag_incoming |-> $past(diag_irq_enable))
        else $error("incoming event while disabled");
endmodule : sod_output_port_checker
